/* ect_regs.svh */
`ifndef ECT_REGS_SVH
`define ECT_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ECT_OFS_CTRL    3'h0
`define ECT_OFS_STAT    3'h1
`define ECT_OFS_CMP     3'h2
`define ECT_OFS_CNT     3'h3
`define ECT_OFS_TBC     3'h4
`define ECT_OFS_PORT    3'h5
// ----------------------------------------
// control field positions
// ----------------------------------------
`define ECT_CTRL_EVIE   7
`define ECT_CTRL_MIE    6
`define ECT_CTRL_CSEL   4
`define ECT_CTRL_IMODE  3
`define ECT_CTRL_IPOL   2
`define ECT_CTRL_OE     1
`define ECT_CTRL_OEDGE  0
`define ECT_CTRL_MASK   8'hDF
// ----------------------------------------
// status field positions
// ----------------------------------------
`define ECT_STAT_EVF    7
`define ECT_STAT_MF     6
`define ECT_STAT_EVCLR  3
`define ECT_STAT_MCLR   2
// ----------------------------------------
// port bits: out data, out dir, in dir
// ----------------------------------------
`define ECT_PORT_ODATA  0
`define ECT_PORT_ODIR   1
`define ECT_PORT_IDIR   2
// ----------------------------------------
// reset values and prescale divisions
// ----------------------------------------
`define ECT_RST_REG     8'h00
`define ECT_CNT_PRESET  8'h01
`define ECT_DIV_1       8'h00
`define ECT_DIV_4       8'h03
`define ECT_DIV_32      8'h1F
`define ECT_DIV_256     8'hFF
`endif

/* ect_pkg.sv */
package ect_pkg;
    typedef logic [7:0] ect_byte_t;
    typedef logic [2:0] ect_addr_t;
endpackage

/* ect_timer.sv */
`timescale 1ns/1ps
`include "ect_regs.svh"
// Function
// - event interrupt requested only with its enable and flag set; enable resets clear.
// - match interrupt requested only with its enable and flag set; enable resets clear.
// - clock select 0 picks prescaled clock, 1 picks external clock; resets clear.
// - edge mode counts chosen edge; gated mode counts while chosen level holds.
// - output enable change takes effect at next output edge chosen by edge select.
// - counter write loads divide-by-two stage with the edge select level.
// - event flag sets on active edge, or on gate active-to-inactive transition.
// - event flag read only; cleared by reset or writing one to its clear bit.
// - match flag read only; cleared by reset or writing one to its clear bit.
// - compare copied to buffer on counter write, match preset, and reset.
// - buffer equal to counter sets match flag and presets counter to one.
// - counter increments on selected timer clock, synchronous to system clock.
// - counter becomes one on reset and on every counter write.
// - prescale code divides system clock by 1, 4, 32 or 256; resets clear.
// - event input passes a two-stage synchroniser before use.
// - gated mode passes prescaled clock only while input is at active level.
// - divide-by-two stage toggles on each match pulse for 50 percent output.
// - pin driven when direction set or synced enable high; idle shows data latch.
// - direction clear and clock off leaves pin undriven.
// - match latched in current timer cycle, pulse issued when next cycle begins.
// - preset from match or write wins over a simultaneous increment.
// - unused control and status bits read as zero.
module ect_timer (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           nrst,
    // register port
    input  wire ect_pkg::ect_addr_t addr,
    input  wire ect_pkg::ect_byte_t wdata,
    input  wire logic           wr,
    input  wire logic           rd,
    output ect_pkg::ect_byte_t  rdata,
    // pins
    input  wire logic           event_in_pin,
    output logic                clock_out_pin_o,
    output logic                clock_out_pin_oe_n,
    output logic                in_pin_direction,
    // interrupt request
    output logic                irq
);
    import ect_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    ect_byte_t ctrl_ff;
    ect_byte_t tbc_ff;
    ect_byte_t cmp_ff;
    ect_byte_t cmp_buf_ff;
    ect_byte_t cnt_ff;
    logic [2:0] port_ff;
    logic       evf_ff;
    logic       mf_ff;
    logic [7:0] pre_ff;
    logic       sync1_ff;
    logic       sync2_ff;
    logic       evi_prev_ff;
    logic       match_ff;
    logic       div_ff;
    logic       div_prev_ff;
    logic       oe_sync_ff;
    logic       tick;
    logic       ext_tick;
    logic       gate_act;
    logic       ev_edge;
    logic       gate_end;
    logic       cnt_wr;
    logic       preset;
    logic       out_edge;
    ect_byte_t  nxt_rdata;

    function automatic logic sel(input ect_addr_t a, input ect_addr_t o);
        sel = (a == o);
    endfunction

    assign cnt_wr = wr && sel(addr, `ECT_OFS_CNT);

    // ----------------------------------------
    // control, prescale and port registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= `ECT_RST_REG;
            tbc_ff  <= `ECT_RST_REG;
            cmp_ff  <= `ECT_RST_REG;
            port_ff <= 3'h0;
        end else if (wr) begin
            if (sel(addr, `ECT_OFS_CTRL))
                ctrl_ff <= wdata & `ECT_CTRL_MASK;
            if (sel(addr, `ECT_OFS_TBC))
                tbc_ff <= {6'h00, wdata[1:0]};
            if (sel(addr, `ECT_OFS_CMP))
                cmp_ff <= wdata;
            if (sel(addr, `ECT_OFS_PORT))
                port_ff <= wdata[2:0];
        end
    end

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    function automatic ect_byte_t div_mask(input logic [1:0] c);
        case (c)
            2'b00:   div_mask = `ECT_DIV_1;
            2'b01:   div_mask = `ECT_DIV_4;
            2'b10:   div_mask = `ECT_DIV_32;
            default: div_mask = `ECT_DIV_256;
        endcase
    endfunction

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            pre_ff <= 8'h00;
        else
            pre_ff <= pre_ff + 8'h01;
    end

    logic pre_tick;
    assign pre_tick = ((pre_ff & div_mask(tbc_ff[1:0])) == 8'h00);

    // ----------------------------------------
    // event input synchroniser and modes
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_ff    <= 1'b0;
            sync2_ff    <= 1'b0;
            evi_prev_ff <= 1'b0;
        end else begin
            sync1_ff    <= event_in_pin;
            sync2_ff    <= sync1_ff;
            evi_prev_ff <= sync2_ff;
        end
    end

    assign gate_act = (sync2_ff == ctrl_ff[`ECT_CTRL_IPOL]);
    assign ev_edge  = (sync2_ff != evi_prev_ff) && gate_act;
    assign gate_end = (evi_prev_ff == ctrl_ff[`ECT_CTRL_IPOL]) && !gate_act;
    assign ext_tick = ctrl_ff[`ECT_CTRL_IMODE] ? (pre_tick && gate_act) : ev_edge;
    assign tick     = ctrl_ff[`ECT_CTRL_CSEL] ? ext_tick : pre_tick;

    // ----------------------------------------
    // counter, compare buffer, match latch
    // ----------------------------------------
    logic match_hit;
    // an equal count seen in the same cycle as the tick presets at once,
    // so the count runs 1..compare and never shows compare plus one
    assign match_hit = match_ff || (cmp_buf_ff == cnt_ff);
    assign preset    = tick && match_hit;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff     <= `ECT_CNT_PRESET;
            cmp_buf_ff <= `ECT_RST_REG;
            match_ff   <= 1'b0;
        end else if (cnt_wr || preset) begin
            cnt_ff     <= `ECT_CNT_PRESET;
            cmp_buf_ff <= cmp_ff;
            match_ff   <= 1'b0;
        end else begin
            if (tick)
                cnt_ff <= cnt_ff + 8'h01;
            if (cmp_buf_ff == cnt_ff)
                match_ff <= 1'b1;
        end
    end

    // ----------------------------------------
    // status flags, set wins over clear
    // ----------------------------------------
    logic st_wr;
    logic ev_set;
    assign st_wr  = wr && sel(addr, `ECT_OFS_STAT);
    assign ev_set = ctrl_ff[`ECT_CTRL_IMODE] ? gate_end : ev_edge;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            evf_ff <= 1'b0;
            mf_ff  <= 1'b0;
        end else begin
            if (ev_set)
                evf_ff <= 1'b1;
            else if (st_wr && wdata[`ECT_STAT_EVCLR])
                evf_ff <= 1'b0;
            if (preset)
                mf_ff <= 1'b1;
            else if (st_wr && wdata[`ECT_STAT_MCLR])
                mf_ff <= 1'b0;
        end
    end

    assign irq = (ctrl_ff[`ECT_CTRL_EVIE] && evf_ff)
              || (ctrl_ff[`ECT_CTRL_MIE] && mf_ff);

    // ----------------------------------------
    // output divider and enable sync
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_ff      <= 1'b0;
            div_prev_ff <= 1'b0;
        end else begin
            div_prev_ff <= div_ff;
            if (cnt_wr)
                div_ff <= ctrl_ff[`ECT_CTRL_OEDGE];
            else if (preset)
                div_ff <= ~div_ff;
        end
    end

    assign out_edge = (div_ff != div_prev_ff) && (div_ff == ctrl_ff[`ECT_CTRL_OEDGE]);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            oe_sync_ff <= 1'b0;
        else if (out_edge)
            oe_sync_ff <= ctrl_ff[`ECT_CTRL_OE];
    end

    assign clock_out_pin_oe_n = !(port_ff[`ECT_PORT_ODIR] || oe_sync_ff);
    assign clock_out_pin_o    = oe_sync_ff ? div_prev_ff : port_ff[`ECT_PORT_ODATA];
    assign in_pin_direction   = port_ff[`ECT_PORT_IDIR];

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_comb begin
        nxt_rdata = 8'h00;
        case (addr)
            `ECT_OFS_CTRL: nxt_rdata = ctrl_ff;
            `ECT_OFS_STAT: nxt_rdata = {evf_ff, mf_ff, 6'h00};
            `ECT_OFS_CMP:  nxt_rdata = cmp_ff;
            `ECT_OFS_CNT:  nxt_rdata = cnt_ff;
            `ECT_OFS_TBC:  nxt_rdata = tbc_ff;
            `ECT_OFS_PORT: nxt_rdata = {5'h00, port_ff};
            default:       nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            rdata <= 8'h00;
        else if (rd)
            rdata <= nxt_rdata;
        else
            rdata <= 8'h00;
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_irq_from_flags: assert property (irq == ((ctrl_ff[7] && evf_ff) || (ctrl_ff[6] && mf_ff)))
        else $error("irq does not match enabled flags");
    a_cnt_wr_preset: assert property (cnt_wr |=> cnt_ff == 8'h01)
        else $error("counter not one after write");
    a_preset_sets_flag: assert property (preset |=> mf_ff && cnt_ff == 8'h01)
        else $error("match preset missing");
    a_wr_loads_buf: assert property (cnt_wr |=> cmp_buf_ff == $past(cmp_ff))
        else $error("buffer not loaded");
    a_inc_on_tick: assert property (tick && !preset && !cnt_wr |=> cnt_ff == $past(cnt_ff) + 8'h01)
        else $error("counter did not increment");
    a_hold_no_tick: assert property (!tick && !cnt_wr |=> cnt_ff == $past(cnt_ff))
        else $error("counter moved without tick");
    a_div_toggle: assert property (preset && !cnt_wr |=> div_ff != $past(div_ff))
        else $error("divider did not toggle");
    a_div_load: assert property (cnt_wr |=> div_ff == $past(ctrl_ff[0]))
        else $error("divider not loaded");
    a_evf_set: assert property (ev_edge && !ctrl_ff[3] |=> evf_ff)
        else $error("event flag not set");
    a_pin_hiz: assert property (!port_ff[1] && !oe_sync_ff |-> clock_out_pin_oe_n)
        else $error("pin driven while off");

    // ----------------------------------------
    // interrupt and clock source checks
    // ----------------------------------------
    a_evt_irq_off: assert property (!ctrl_ff[7] && !(ctrl_ff[6] && mf_ff) |-> !irq)
        else $error("event irq without enable");

    a_match_irq_off: assert property (!ctrl_ff[6] && !(ctrl_ff[7] && evf_ff) |-> !irq)
        else $error("match irq without enable");

    a_csel_pre: assert property (!ctrl_ff[4] |-> tick == pre_tick)
        else $error("prescaled clock not selected");

    a_edge_count: assert property (ctrl_ff[4] && !ctrl_ff[3] && tick
        |-> sync2_ff != evi_prev_ff && sync2_ff == ctrl_ff[2])
        else $error("tick without active edge");

    a_gate_count: assert property (ctrl_ff[4] && ctrl_ff[3] && !gate_act |-> !tick)
        else $error("tick outside gate level");

    a_div4_rate: assert property (tbc_ff[1:0] == 2'b01 && pre_tick |=> !pre_tick)
        else $error("prescale by four too fast");

    // ----------------------------------------
    // flag, buffer and counter checks
    // ----------------------------------------
    a_gate_flag: assert property (gate_end && ctrl_ff[3] |=> evf_ff)
        else $error("gate end did not set flag");

    a_evf_clear: assert property (st_wr && wdata[3] && !ev_set |=> !evf_ff)
        else $error("event flag not cleared");

    a_mf_clear: assert property (st_wr && wdata[2] && !preset |=> !mf_ff)
        else $error("match flag not cleared");

    a_preset_buf: assert property (preset |=> cmp_buf_ff == $past(cmp_ff))
        else $error("buffer not loaded on preset");

    a_wr_wins: assert property (tick && cnt_wr |=> cnt_ff == 8'h01)
        else $error("increment beat counter write");

    a_match_latch: assert property (cmp_buf_ff == cnt_ff && !cnt_wr && !preset |=> match_ff)
        else $error("match not latched");

    // ----------------------------------------
    // pin and read-back checks
    // ----------------------------------------
    a_pin_drive: assert property (port_ff[1] |-> !clock_out_pin_oe_n)
        else $error("pin not driven with direction set");

    a_pin_data: assert property (port_ff[1] && !oe_sync_ff |-> clock_out_pin_o == port_ff[0])
        else $error("idle pin not port data");

    a_oe_hold: assert property (!out_edge |=> oe_sync_ff == $past(oe_sync_ff))
        else $error("enable switched off edge");

    a_stat_zero: assert property (rd && addr == 3'h1 |=> rdata[5:0] == 6'h00)
        else $error("status unused bits set");


    c_match_preset: cover property (preset);
    c_event_edge:   cover property (ev_edge && ctrl_ff[4]);
    c_gate_end:     cover property (gate_end && ctrl_ff[3]);
    c_out_on:       cover property (out_edge && ctrl_ff[1]);
    c_div_load:     cover property (cnt_wr && ctrl_ff[0]);
endmodule

/* ect_partner.sv */
`timescale 1ns/1ps
// ----------------------------------------
// event source and output pin load
// ----------------------------------------
module ect_partner (
    // clock
    input  wire logic clk,
    // stimulus and pin from block
    input  wire logic ev_req,
    input  wire logic pin_o,
    input  wire logic pin_oe_n,
    // pin levels
    output logic      event_in_pin,
    output logic      pin_level
);
    logic last_ff;
    initial event_in_pin = 1'b0;
    // levels held several clocks; input pin direction stays clear
    always @(posedge clk) event_in_pin <= ev_req;
    // undriven pin shows the inverse of its last driven level
    always @(posedge clk) if (!pin_oe_n) last_ff <= pin_o;
    assign pin_level = pin_oe_n ? ~last_ff : pin_o;
endmodule

/* event_counter_timer_test.sv */
`timescale 1ns/1ps
`include "ect_regs.svh"
module event_counter_timer_test;
    import ect_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic      clk = 1'b0;
    logic      nrst = 1'b0;
    ect_addr_t addr = 3'h0;
    ect_byte_t wdata = 8'h00;
    logic      wr = 1'b0;
    logic      rd = 1'b0;
    logic      ev_req = 1'b0;
    ect_byte_t rdata;
    ect_byte_t v;
    logic      evt, pin_o, pin_oe_n, in_dir, irq, pin_lvl;
    int        num_errors = 0;
    int        n_checks = 0;
    always #5 clk = ~clk;
    ect_timer i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .event_in_pin(evt), .clock_out_pin_o(pin_o),
        .clock_out_pin_oe_n(pin_oe_n), .in_pin_direction(in_dir), .irq(irq));
    ect_partner i_far (.clk(clk), .ev_req(ev_req), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .event_in_pin(evt), .pin_level(pin_lvl));
    // ----------------------------------------
    // compare and bus tasks
    // ----------------------------------------
    task automatic chk8(ect_byte_t got, ect_byte_t exp, string m);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk1(logic got, logic exp, string m);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %b", $time, m, got);
        end
    endtask
    task automatic wr_reg(ect_addr_t a, ect_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(ect_addr_t a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic pulse(logic lvl);
        @(posedge clk);
        ev_req <= lvl;
        repeat (4) @(posedge clk);
        ev_req <= ~lvl;
        repeat (4) @(posedge clk);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        for (int a = 0; a < 8; a++) begin
            rd_reg(a[2:0]);
            chk8(v, (a == 3) ? 8'h08 : `ECT_RST_REG, "reset value");
        end
        chk1(irq, 1'b0, "irq idle");
        chk1(pin_oe_n, 1'b1, "pin idle");
        $display("test reset done");
    endtask
    task automatic t_regs;
        wr_reg(`ECT_OFS_CTRL, 8'hFC);
        rd_reg(`ECT_OFS_CTRL);
        chk8(v, 8'hDC, "ctrl bits");
        wr_reg(`ECT_OFS_STAT, 8'hFF);
        rd_reg(`ECT_OFS_STAT);
        chk8(v, 8'h00, "status write");
        wr_reg(`ECT_OFS_TBC, 8'hFF);
        rd_reg(`ECT_OFS_TBC);
        chk8(v, 8'h03, "prescale field");
        $display("test regs done");
    endtask
    task automatic t_rate;
        int dv[4] = '{1, 4, 32, 256};
        wr_reg(`ECT_OFS_CMP, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr_reg(`ECT_OFS_TBC, c[7:0]);
            wr_reg(`ECT_OFS_CTRL, 8'h00);
            wr_reg(`ECT_OFS_CNT, 8'h00);
            repeat (8 * dv[c]) @(posedge clk);
            wr_reg(`ECT_OFS_CTRL, 8'h10);
            rd_reg(`ECT_OFS_CNT);
            chk1(v >= 8 && v <= 11, 1'b1, "prescale rate");
        end
        wr_reg(`ECT_OFS_TBC, 8'h00);
        $display("test rate done");
    endtask
    task automatic t_match;
        wr_reg(`ECT_OFS_CMP, 8'h05);
        wr_reg(`ECT_OFS_CTRL, 8'h40);
        wr_reg(`ECT_OFS_CNT, 8'h00);
        for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge clk);
        chk1(irq, 1'b1, "match irq");
        wr_reg(`ECT_OFS_CTRL, 8'h50);
        rd_reg(`ECT_OFS_STAT);
        chk8(v, 8'h40, "match flag");
        rd_reg(`ECT_OFS_CNT);
        chk1(v >= 1 && v <= 5, 1'b1, "preset wraps");
        wr_reg(`ECT_OFS_STAT, 8'h04);
        chk1(irq, 1'b0, "match irq cleared");
        $display("test match done");
    endtask
    task automatic t_edge;
        for (int p = 0; p < 2; p++) begin
            ev_req <= ~p[0];
            repeat (4) @(posedge clk);
            wr_reg(`ECT_OFS_CTRL, 8'h90 | {5'h0, p[0], 2'h0});
            wr_reg(`ECT_OFS_CNT, 8'h00);
            wr_reg(`ECT_OFS_STAT, 8'h08);
            repeat (3) pulse(p[0]);
            rd_reg(`ECT_OFS_CNT);
            chk8(v, 8'h04, "edge count");
            chk1(irq, 1'b1, "event irq");
            wr_reg(`ECT_OFS_STAT, 8'h08);
            chk1(irq, 1'b0, "event irq cleared");
        end
        $display("test edge done");
    endtask
    task automatic t_gate;
        wr_reg(`ECT_OFS_TBC, 8'h01);
        wr_reg(`ECT_OFS_CMP, 8'h00);
        for (int p = 0; p < 2; p++) begin
            ev_req <= ~p[0];
            wr_reg(`ECT_OFS_CTRL, 8'h18 | {5'h0, p[0], 2'h0});
            wr_reg(`ECT_OFS_CNT, 8'h00);
            wr_reg(`ECT_OFS_STAT, 8'h08);
            @(posedge clk);
            ev_req <= p[0];
            repeat (40) @(posedge clk);
            ev_req <= ~p[0];
            repeat (6) @(posedge clk);
            rd_reg(`ECT_OFS_CNT);
            chk1(v >= 9 && v <= 12, 1'b1, "gated count");
            rd_reg(`ECT_OFS_STAT);
            chk8(v, 8'h80, "gate end flag");
        end
        wr_reg(`ECT_OFS_TBC, 8'h00);
        $display("test gate done");
    endtask
    task automatic t_out;
        int   n;
        logic prev;
        wr_reg(`ECT_OFS_PORT, 8'h03);
        chk1(pin_oe_n, 1'b0, "port drive");
        chk1(pin_o, 1'b1, "port data");
        wr_reg(`ECT_OFS_PORT, 8'h00);
        chk1(pin_oe_n, 1'b1, "pin released");
        wr_reg(`ECT_OFS_CMP, 8'h02);
        wr_reg(`ECT_OFS_CTRL, 8'h10);
        wr_reg(`ECT_OFS_CNT, 8'h00);
        wr_reg(`ECT_OFS_CTRL, 8'h02);
        chk1(pin_oe_n, 1'b1, "enable deferred");
        for (int i = 0; i < 20 && pin_oe_n !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        chk1(pin_oe_n, 1'b0, "enable at edge");
        n = 0;
        prev = pin_lvl;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (pin_lvl !== prev) n++;
            prev = pin_lvl;
        end
        chk1(n >= 19 && n <= 21, 1'b1, "half rate output");
        $display("test out done");
    endtask
    // ----------------------------------------
    // sequence and verdict
    // ----------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_regs;
        t_rate;
        t_match;
        t_edge;
        t_gate;
        t_out;
        finish_test;
    end
    initial begin
        #200000;
        num_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        finish_test;
    end
endmodule
